// ### inc/dmapi_pkg.sv
// shared constants and types of the dma programming port
`default_nettype none
package dmapi_pkg;
    localparam int NSLOT = 14;
    localparam int NRD = 7;
    // associated register slots, in write order
    localparam logic [3:0] SL_A_LO = 4'h0;
    localparam logic [3:0] SL_A_HI = 4'h1;
    localparam logic [3:0] SL_LEN_LO = 4'h2;
    localparam logic [3:0] SL_LEN_HI = 4'h3;
    localparam logic [3:0] SL_TIM_A = 4'h4;
    localparam logic [3:0] SL_TIM_B = 4'h5;
    localparam logic [3:0] SL_MASK = 4'h6;
    localparam logic [3:0] SL_MATCH = 4'h7;
    localparam logic [3:0] SL_B_LO = 4'h8;
    localparam logic [3:0] SL_B_HI = 4'h9;
    localparam logic [3:0] SL_INT = 4'hA;
    localparam logic [3:0] SL_PULSE = 4'hB;
    localparam logic [3:0] SL_VEC = 4'hC;
    localparam logic [3:0] SL_RMASK = 4'hD;
    // bit positions within base bytes and the interrupt control byte
    localparam int P_GRP = 7;
    localparam int P_DIR = 2;
    localparam int P_G0_PTR = 3;
    localparam int P_TIM_PTR = 6;
    localparam int P_G3_PTR = 3;
    localparam int P_G4_PTR = 2;
    localparam int P_IC_PTR = 3;
    localparam int P_FIX = 5;
    localparam int P_INC = 4;
    // group six command codes
    localparam logic [7:0] CMD_RESET = 8'hC3;
    localparam logic [7:0] CMD_LOAD = 8'hCF;
    localparam logic [7:0] CMD_ENABLE = 8'h87;
    localparam logic [7:0] CMD_DISABLE = 8'h83;
    localparam logic [7:0] CMD_RD_STATUS = 8'hBF;
    localparam logic [7:0] CMD_INIT_RD = 8'hA7;
    localparam logic [7:0] CMD_RMASK = 8'hBB;
    // address counter modes
    localparam logic [1:0] MODE_DEC = 2'h0;
    localparam logic [1:0] MODE_INC = 2'h1;
    localparam logic [1:0] MODE_FIX = 2'h2;
    // reset values and status bits
    localparam logic [6:0] RMASK_RST = 7'h7F;
    localparam logic [6:0] RD_STATUS_ONLY = 7'h01;
    localparam logic [1:0] MODE_RST = MODE_INC;
    localparam int ST_XFER = 0;
    localparam int ST_REQ = 1;
    localparam int ST_EOB_N = 5;
    typedef enum logic {
        DMAPI_OFF = 1'b0,
        DMAPI_ON = 1'b1
    } dmapi_state_e;
endpackage
`default_nettype wire

// ### inc/dmapi_seq_if.sv
// pending-slot sequencer handshake between the top and its sequencers
`default_nettype none
interface dmapi_seq_if #(parameter int N = 8) ();
    localparam int W = $clog2(N);
    logic load;
    logic [N-1:0] load_bits;
    logic take;
    logic busy;
    logic [W-1:0] slot;
    modport ctl(output load, output load_bits, output take,
                input busy, input slot);
    modport seq(input load, input load_bits, input take,
                output busy, output slot);
endinterface
`default_nettype wire

// ### verilog/dmapi_wseq.sv
// write sequencer: walks pointed associated registers lowest first
`default_nettype none
module dmapi_wseq
    import dmapi_pkg::*;
#(
    parameter int N = NSLOT
) (
    input wire logic clk,
    input wire logic rst_n,
    dmapi_seq_if.seq sq
);
    localparam int W = $clog2(N);
    logic [N-1:0] pend_q;
    logic [W-1:0] slot_c;

    if (N < 2 || N > 16) begin : g_chk
        $error("dmapi_wseq: N out of range");
    end

    always_comb begin
        slot_c = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                slot_c = W'(i);
            end
        end
    end

    assign sq.slot = slot_c;
    assign sq.busy = |pend_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
        end else if (sq.load) begin
            pend_q <= sq.load_bits;
        end else if (sq.take) begin
            pend_q <= pend_q & ~(N'(1) << slot_c);
        end
    end
endmodule
`default_nettype wire

// ### verilog/dmapi_rseq.sv
// read sequencer: masked ascending walk that wraps to the mask again
`default_nettype none
module dmapi_rseq
    import dmapi_pkg::*;
#(
    parameter int N = NRD
) (
    input wire logic clk,
    input wire logic rst_n,
    dmapi_seq_if.seq sq
);
    localparam int W = $clog2(N);
    logic [N-1:0] pend_q;
    logic [N-1:0] mask_q;
    logic [N-1:0] rest;
    logic [W-1:0] slot_c;

    if (N < 2 || N > 8) begin : g_chk
        $error("dmapi_rseq: N out of range");
    end

    always_comb begin
        slot_c = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                slot_c = W'(i);
            end
        end
    end

    assign rest = pend_q & ~(N'(1) << slot_c);
    assign sq.slot = slot_c;
    assign sq.busy = |pend_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            mask_q <= '0;
        end else if (sq.load) begin
            pend_q <= sq.load_bits;
            mask_q <= sq.load_bits;
        end else if (sq.take) begin
            pend_q <= (rest == '0) ? mask_q : rest;
        end
    end
endmodule
`default_nettype wire

// ### verilog/dmapi_top.sv
// host programming port of a single-channel two-port dma controller
`default_nettype none
// What this block does
// - enabled state may request buses; disabled state requests nothing
// - power-up and every reset leave the controller disabled
// - any host byte disables; only the enable command re-enables
// - each group access starts with its base byte
// - base byte holds group id and pointer bits for its registers; pulse and vector are pointed from the int byte
// - following bytes fill pointed registers in order, skipping clear
// - group zero base is known from bits 0, 1 and 7
// - group zero order: port A start low, high, length low, high
// - groups one, two give timing bytes; group three mask then match
// - group four: B start low, high, int, pulse, vector; six: read mask
// - host reads status and counters through port input cycles
// - reads walk registers zero to six, skipping masked ones
// - read order: status, byte count, port A count, port B count
// - initiate-read or read-status command restarts the read walk
// - load copies start address into source port counter only
// - one byte more than the block length is transferred
// - all registers are eight bits except the seven-bit read mask, low byte first
// - addressed only with chip enable, io strobe and read or write
module dmapi_top
    import dmapi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce_n,
    input wire logic io_request_strobe_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] d_in,
    output logic [7:0] d_out,
    output logic d_oe,
    input wire logic xfer_step,
    output logic bus_req,
    output logic dma_enabled,
    output logic src_is_a,
    output logic [15:0] port_a_addr,
    output logic [15:0] port_b_addr,
    output logic [7:0] timing_a,
    output logic [7:0] timing_b,
    output logic [7:0] search_mask,
    output logic [7:0] match_byte,
    output logic [7:0] int_ctrl,
    output logic [7:0] pulse_ctrl,
    output logic [7:0] int_vector,
    output logic [7:0] ctrl_five
);
    dmapi_seq_if #(.N(NSLOT)) wif ();
    dmapi_seq_if #(.N(NRD)) rif ();

    dmapi_state_e state_q;
    logic wr_acc, rd_acc, wr_prev_q, rd_prev_q, wstb, rstb, rend;
    logic base, is_g0, is_g1, is_g2, is_g3, is_g4, is_g5, is_g6;
    logic cmd_reset, cmd_load, cmd_en, cmd_rd_st, cmd_init, cmd_rmask;
    logic ic_wr, done, step_ok, xfer_seen_q;
    logic [1:0] a_mode_q, b_mode_q;
    logic [6:0] rmask_q;
    logic [15:0] a_start_q, b_start_q, len_q, a_cnt_q, b_cnt_q;
    logic [16:0] byte_cnt_q;
    logic [7:0] status, rd_val, d_out_q;

    dmapi_wseq #(.N(NSLOT)) u_wseq (
        .clk(clk),
        .rst_n(rst_n),
        .sq(wif.seq)
    );

    dmapi_rseq #(.N(NRD)) u_rseq (
        .clk(clk),
        .rst_n(rst_n),
        .sq(rif.seq)
    );

    // host access decode and strobe edges
    assign wr_acc = !ce_n && !io_request_strobe_n && !wr_n;
    assign rd_acc = !ce_n && !io_request_strobe_n && !rd_n && wr_n;
    assign wstb = wr_acc && !wr_prev_q;
    assign rstb = rd_acc && !rd_prev_q;
    assign rend = !rd_acc && rd_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
        end else begin
            wr_prev_q <= wr_acc;
            rd_prev_q <= rd_acc;
        end
    end

    // base byte decode; only when no pointed register is pending
    assign base = wstb && !wif.busy;
    assign is_g0 = base && !d_in[P_GRP] && d_in[1:0] != 2'h0;
    assign is_g1 = base && !d_in[P_GRP] && d_in[2:0] == 3'h4;
    assign is_g2 = base && !d_in[P_GRP] && d_in[2:0] == 3'h0;
    assign is_g3 = base && d_in[P_GRP] && d_in[1:0] == 2'h0;
    assign is_g4 = base && d_in[P_GRP] && d_in[1:0] == 2'h1;
    assign is_g5 = base && d_in[P_GRP] && d_in[2:0] == 3'h2 && !d_in[6];
    assign is_g6 = base && d_in[P_GRP] && d_in[1:0] == 2'h3;
    assign cmd_reset = is_g6 && d_in == CMD_RESET;
    assign cmd_load = is_g6 && d_in == CMD_LOAD;
    assign cmd_en = is_g6 && d_in == CMD_ENABLE;
    assign cmd_rd_st = is_g6 && d_in == CMD_RD_STATUS;
    assign cmd_init = is_g6 && d_in == CMD_INIT_RD;
    assign cmd_rmask = is_g6 && d_in == CMD_RMASK;
    assign ic_wr = wif.take && wif.slot == SL_INT;

    // pointer bits select the associated registers to follow
    assign wif.take = wstb && wif.busy;
    always_comb begin
        wif.load = is_g0 || is_g1 || is_g2 || is_g3 || is_g4 || is_g6
            || ic_wr;
        wif.load_bits = '0;
        if (is_g0) begin
            wif.load_bits[SL_A_LO] = d_in[P_G0_PTR];
            wif.load_bits[SL_A_HI] = d_in[P_G0_PTR + 1];
            wif.load_bits[SL_LEN_LO] = d_in[P_G0_PTR + 2];
            wif.load_bits[SL_LEN_HI] = d_in[P_G0_PTR + 3];
        end
        if (is_g1) begin
            wif.load_bits[SL_TIM_A] = d_in[P_TIM_PTR];
        end
        if (is_g2) begin
            wif.load_bits[SL_TIM_B] = d_in[P_TIM_PTR];
        end
        if (is_g3) begin
            wif.load_bits[SL_MASK] = d_in[P_G3_PTR];
            wif.load_bits[SL_MATCH] = d_in[P_G3_PTR + 1];
        end
        if (is_g4) begin
            wif.load_bits[SL_B_LO] = d_in[P_G4_PTR];
            wif.load_bits[SL_B_HI] = d_in[P_G4_PTR + 1];
            wif.load_bits[SL_INT] = d_in[P_G4_PTR + 2];
        end
        if (ic_wr) begin
            wif.load_bits[SL_PULSE] = d_in[P_IC_PTR];
            wif.load_bits[SL_VEC] = d_in[P_IC_PTR + 1];
        end
        if (cmd_rmask) begin
            wif.load_bits[SL_RMASK] = 1'b1;
        end
    end

    // associated register stores, one byte each
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_start_q <= '0;
            b_start_q <= '0;
            len_q <= '0;
            timing_a <= '0;
            timing_b <= '0;
            search_mask <= '0;
            match_byte <= '0;
            int_ctrl <= '0;
            pulse_ctrl <= '0;
            int_vector <= '0;
            rmask_q <= RMASK_RST;
        end else if (wif.take) begin
            unique case (wif.slot)
                SL_A_LO: a_start_q[7:0] <= d_in;
                SL_A_HI: a_start_q[15:8] <= d_in;
                SL_LEN_LO: len_q[7:0] <= d_in;
                SL_LEN_HI: len_q[15:8] <= d_in;
                SL_TIM_A: timing_a <= d_in;
                SL_TIM_B: timing_b <= d_in;
                SL_MASK: search_mask <= d_in;
                SL_MATCH: match_byte <= d_in;
                SL_B_LO: b_start_q[7:0] <= d_in;
                SL_B_HI: b_start_q[15:8] <= d_in;
                SL_INT: int_ctrl <= d_in;
                SL_PULSE: pulse_ctrl <= d_in;
                SL_VEC: int_vector <= d_in;
                SL_RMASK: rmask_q <= d_in[6:0];
                default: rmask_q <= rmask_q;
            endcase
        end
    end

    function automatic logic [1:0] mode_of(input logic [7:0] b);
        logic [1:0] m;
        m = b[P_INC] ? MODE_INC : MODE_DEC;
        if (b[P_FIX]) begin
            m = MODE_FIX;
        end
        return m;
    endfunction

    function automatic logic [15:0] step_addr(input logic [15:0] a,
                                              input logic [1:0] m);
        logic [15:0] r;
        r = a;
        if (m == MODE_INC) begin
            r = a + 16'h1;
        end
        if (m == MODE_DEC) begin
            r = a - 16'h1;
        end
        return r;
    endfunction

    // control bits carried in base bytes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_is_a <= 1'b1;
            a_mode_q <= MODE_RST;
            b_mode_q <= MODE_RST;
            ctrl_five <= '0;
        end else begin
            if (is_g0) begin
                src_is_a <= d_in[P_DIR];
            end
            if (is_g1) begin
                a_mode_q <= mode_of(d_in);
            end
            if (is_g2) begin
                b_mode_q <= mode_of(d_in);
            end
            if (is_g5) begin
                ctrl_five <= d_in;
            end
        end
    end

    // enabled / disabled state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DMAPI_OFF;
        end else if (wstb) begin
            state_q <= cmd_en ? DMAPI_ON : DMAPI_OFF;
        end
    end

    assign dma_enabled = state_q == DMAPI_ON;
    assign done = byte_cnt_q == {1'b0, len_q} + 17'h1;
    assign bus_req = dma_enabled && !done;
    assign step_ok = xfer_step && bus_req;

    // byte and address counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_cnt_q <= '0;
            a_cnt_q <= '0;
            b_cnt_q <= '0;
        end else if (cmd_reset) begin
            byte_cnt_q <= '0;
            a_cnt_q <= '0;
            b_cnt_q <= '0;
        end else if (cmd_load) begin
            byte_cnt_q <= '0;
            if (src_is_a) begin
                a_cnt_q <= a_start_q;
            end else begin
                b_cnt_q <= b_start_q;
            end
        end else if (step_ok) begin
            byte_cnt_q <= byte_cnt_q + 17'h1;
            a_cnt_q <= step_addr(a_cnt_q, a_mode_q);
            b_cnt_q <= step_addr(b_cnt_q, b_mode_q);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_seen_q <= 1'b0;
        end else if (step_ok) begin
            xfer_seen_q <= 1'b1;
        end else if (cmd_reset) begin
            xfer_seen_q <= 1'b0;
        end
    end

    assign port_a_addr = a_cnt_q;
    assign port_b_addr = b_cnt_q;

    // read walk and read data
    always_comb begin
        status = '0;
        status[ST_XFER] = xfer_seen_q;
        status[ST_REQ] = bus_req;
        status[ST_EOB_N] = !done;
    end

    assign rif.load = cmd_init || cmd_rd_st || cmd_reset;
    assign rif.load_bits = cmd_init ? rmask_q :
        (cmd_rd_st ? RD_STATUS_ONLY : '0);
    assign rif.take = rend && rif.busy;

    always_comb begin
        unique case (rif.slot)
            3'h1: rd_val = byte_cnt_q[7:0];
            3'h2: rd_val = byte_cnt_q[15:8];
            3'h3: rd_val = a_cnt_q[7:0];
            3'h4: rd_val = a_cnt_q[15:8];
            3'h5: rd_val = b_cnt_q[7:0];
            3'h6: rd_val = b_cnt_q[15:8];
            default: rd_val = status;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            d_out_q <= '0;
        end else if (rstb) begin
            d_out_q <= rd_val;
        end
    end

    assign d_out = d_out_q;
    assign d_oe = rd_acc;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_g0_alo;
        is_g0 && d_in[P_G0_PTR] && !d_in[P_G0_PTR + 1];
    endsequence
    sequence s_enable;
        wstb && cmd_en;
    endsequence

    property p_no_req_off;
        !dma_enabled |-> !bus_req && !step_ok;
    endproperty
    a_no_req_off: assert property (p_no_req_off)
        else $error("bus request while disabled");

    property p_reset_cmd;
        cmd_reset |=> !dma_enabled && !rif.busy && byte_cnt_q == 17'h0;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd)
        else $error("reset command did not clear state");

    property p_write_off;
        s_enable ##[2:8] (wstb && !cmd_en) |=> !dma_enabled;
    endproperty
    a_write_off: assert property (p_write_off)
        else $error("host byte left controller enabled");

    property p_enable;
        s_enable |=> dma_enabled;
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable command ignored");

    property p_g0_order;
        s_g0_alo |=> wif.busy && wif.slot == SL_A_LO;
    endproperty
    a_g0_order: assert property (p_g0_order)
        else $error("group zero pointer not honoured");

    property p_store_low;
        wif.take && wif.slot == SL_A_LO |=> a_start_q[7:0] == $past(d_in);
    endproperty
    a_store_low: assert property (p_store_low)
        else $error("start address low byte not stored");

    property p_back_to_base;
        wif.take && wif.slot == SL_TIM_A |=> !wif.busy;
    endproperty
    a_back_to_base: assert property (p_back_to_base)
        else $error("sequencer stayed busy after last register");

    property p_load_src;
        cmd_load && src_is_a |=>
            a_cnt_q == $past(a_start_q) && b_cnt_q == $past(b_cnt_q);
    endproperty
    a_load_src: assert property (p_load_src)
        else $error("load touched the destination counter");

    property p_count_one_more;
        byte_cnt_q == {1'b0, len_q} && step_ok |=> !bus_req;
    endproperty
    a_count_one_more: assert property (p_count_one_more)
        else $error("block did not end after length plus one");

    property p_rd_status;
        cmd_rd_st |=> rif.busy && rif.slot == 3'h0;
    endproperty
    a_rd_status: assert property (p_rd_status)
        else $error("read status did not restart walk");

    property p_rd_byte_lo;
        rstb && rif.busy && rif.slot == 3'h1 |=>
            d_out == $past(byte_cnt_q[7:0]);
    endproperty
    a_rd_byte_lo: assert property (p_rd_byte_lo)
        else $error("byte counter low read wrong");

    property p_not_addressed;
        ce_n |-> !d_oe && !wstb;
    endproperty
    a_not_addressed: assert property (p_not_addressed)
        else $error("responded without chip enable");
endmodule
`default_nettype wire

// ### bench/dmapi_host.sv
// host cpu model: port write and read cycles towards the programming port
`default_nettype none
module dmapi_host (
    input wire logic clk,
    output logic ce_n,
    output logic io_request_strobe_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] d_in,
    input wire logic [7:0] d_out,
    input wire logic d_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        ce_n = 1'b1;
        io_request_strobe_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        d_in = 8'h00;
    end

    // one byte per strobe, at least one idle cycle after it
    task automatic wr(input logic [7:0] b, input logic ce);
        @(posedge clk);
        ce_n <= ce;
        io_request_strobe_n <= 1'b0;
        wr_n <= 1'b0;
        d_in <= b;
        @(posedge clk);
        ce_n <= 1'b1;
        io_request_strobe_n <= 1'b1;
        wr_n <= 1'b1;
        // released bus shows no stale byte
        d_in <= ~b;
        @(posedge clk);
    endtask

    // input cycle: data is valid from the cycle after the access is taken
    task automatic rd(output logic [7:0] b, output logic oe);
        @(posedge clk);
        ce_n <= 1'b0;
        io_request_strobe_n <= 1'b0;
        rd_n <= 1'b0;
        @(posedge clk);
        oe = d_oe;
        @(posedge clk);
        b = d_out;
        ce_n <= 1'b1;
        io_request_strobe_n <= 1'b1;
        rd_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ### bench/dmapi_tb_top.sv
// self-checking bench of the dma programming port
`default_nettype none
`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        n_fail++; \
        $display("unexpected at %0t got %h exp %h", $time, a, e); \
    end \
end
module dmapi_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0] b;
        logic en;
        logic src;
        logic [15:0] a;
        logic [15:0] pb;
    } dmapi_row_s;
    logic clk, rst_n, ce_n, io_request_strobe_n, rd_n, wr_n, d_oe, xfer_step;
    logic bus_req, en, src_a, oe;
    logic [7:0] d_in, d_out, v, ta, tb, sm, mb, ic, pc, iv, c5;
    logic [15:0] pa, pb;
    int n_fail, cmp_count, n;
    dmapi_row_s rows[14] = '{
        '{8'h79, 1'h0, 1'h0, 16'h0, 16'h0}, '{8'h50, 1'h0, 1'h0, 16'h0, 16'h0},
        '{8'h10, 1'h0, 1'h0, 16'h0, 16'h0}, '{8'h00, 1'h0, 1'h0, 16'h0, 16'h0},
        '{8'h10, 1'h0, 1'h0, 16'h0, 16'h0}, '{8'h14, 1'h0, 1'h0, 16'h0, 16'h0},
        '{8'h28, 1'h0, 1'h0, 16'h0, 16'h0}, '{8'hC5, 1'h0, 1'h0, 16'h0, 16'h0},
        '{8'h05, 1'h0, 1'h0, 16'h0, 16'h0}, '{8'h8A, 1'h0, 1'h0, 16'h0, 16'h0},
        '{8'hCF, 1'h0, 1'h0, 16'h0, 16'h5}, '{8'h05, 1'h0, 1'h1, 16'h0, 16'h5},
        '{8'hCF, 1'h0, 1'h1, 16'h1050, 16'h5},
        '{8'h87, 1'h1, 1'h1, 16'h1050, 16'h5}};
    logic [7:0] rexp[7] = '{8'h01, 8'h01, 8'h10, 8'h51, 8'h20, 8'h05, 8'h00};
    logic [7:0] gb[14] = '{8'h2D, 8'h34, 8'h00, 8'h90, 8'h5A, 8'h44, 8'h0E,
        8'h40, 8'h0F, 8'h91, 8'h18, 8'h22, 8'h33, 8'hCF};

    dmapi_top i_dmapi_top (.clk(clk), .rst_n(rst_n), .ce_n(ce_n),
        .io_request_strobe_n(io_request_strobe_n), .rd_n(rd_n), .wr_n(wr_n), .d_in(d_in),
        .d_out(d_out), .d_oe(d_oe), .xfer_step(xfer_step),
        .bus_req(bus_req), .dma_enabled(en), .src_is_a(src_a),
        .port_a_addr(pa), .port_b_addr(pb), .timing_a(ta), .timing_b(tb),
        .search_mask(sm), .match_byte(mb), .int_ctrl(ic),
        .pulse_ctrl(pc), .int_vector(iv), .ctrl_five(c5));
    dmapi_host i_dmapi_host (.clk(clk), .ce_n(ce_n), .io_request_strobe_n(io_request_strobe_n),
        .rd_n(rd_n), .wr_n(wr_n), .d_in(d_in), .d_out(d_out),
        .d_oe(d_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic summarize;
        $display("mismatches %0d of %0d compares", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic w(input logic [7:0] b);
        i_dmapi_host.wr(b, 1'b0);
    endtask

    task automatic r(input logic [7:0] e);
        i_dmapi_host.rd(v, oe);
        `CHK(v, e)
        `CHK(oe, 1'b1)
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        xfer_step = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        `CHK(en, 1'b0)
        `CHK(src_a, 1'b1)
        `CHK(bus_req, 1'b0)
        // sample program: fixed destination loaded first, then enable
        foreach (rows[i]) begin
            w(rows[i].b);
            `CHK(en, rows[i].en)
            `CHK(bus_req, rows[i].en)
            `CHK(src_a, rows[i].src)
            `CHK(pa, rows[i].a)
            `CHK(pb, rows[i].pb)
        end
        `CHK(c5, 8'h8A)
        `CHK(ta, 8'h00)
        n = 0;
        while (bus_req === 1'b1 && n < 5000) begin
            xfer_step <= 1'b1;
            @(posedge clk);
            xfer_step <= 1'b0;
            @(posedge clk);
            n++;
        end
        `CHK(n, 4097)
        `CHK(pa, 16'h2051)
        `CHK(pb, 16'h0005)
        w(8'hA7);
        foreach (rexp[i]) r(rexp[i]);
        r(8'h01);
        w(8'hBB);
        w(8'h0A);
        w(8'hA7);
        r(8'h01);
        r(8'h51);
        w(8'hBF);
        r(8'h01);
        foreach (gb[i]) w(gb[i]);
        `CHK(pa, 16'h1034)
        `CHK(mb, 8'h5A)
        `CHK(sm, 8'h00)
        `CHK(ta, 8'h0E)
        `CHK(tb, 8'h0F)
        `CHK(ic, 8'h18)
        `CHK(pc, 8'h22)
        `CHK(iv, 8'h33)
        i_dmapi_host.wr(8'h87, 1'b1);
        `CHK(en, 1'b0)
        w(8'h87);
        `CHK(en, 1'b1)
        `CHK(bus_req, 1'b1)
        // a disable byte without chip enable must leave the state alone
        i_dmapi_host.wr(8'h83, 1'b1);
        `CHK(en, 1'b1)
        w(8'h00);
        `CHK(en, 1'b0)
        `CHK(bus_req, 1'b0)
        w(8'h87);
        w(8'hC3);
        `CHK(en, 1'b0)
        `CHK(pa, 16'h0000)
        // walk restarted after the reset command: moved flag cleared
        w(8'hBF);
        r(8'h20);
        // leave non-reset values behind so the pin reset has work to do
        w(8'h01);
        w(8'h87);
        `CHK(src_a, 1'b0)
        `CHK(en, 1'b1)
        rst_n <= 1'b0;
        @(posedge clk);
        `CHK(en, 1'b0)
        `CHK(src_a, 1'b1)
        rst_n <= 1'b1;
        @(posedge clk);
        summarize();
    end
endmodule
`default_nettype wire
